// file: inc/glue_lut_map.vh
// register map, field positions, codes and reset values of the glue-logic unit
`ifndef GLUE_LUT_MAP_VH
`define GLUE_LUT_MAP_VH
// ----------------------------------------
// register indices; the bus byte address is index * 4
// ----------------------------------------
`define IDX_UNIT_CONTROL 8'h00
`define IDX_PAIR_STORAGE 8'h01
`define IDX_T0_CONTROL_A 8'h05
`define IDX_T0_CONTROL_B 8'h06
`define IDX_T0_CONTROL_C 8'h07
`define IDX_T0_PATTERN 8'h08
`define IDX_T1_CONTROL_A 8'h09
`define IDX_T1_CONTROL_B 8'h0a
`define IDX_T1_CONTROL_C 8'h0b
`define IDX_T1_PATTERN 8'h0c
`define IDX_SLEEP_CONTROL 8'h10
`define IDX_STATUS 8'h11
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_ENABLE 0
`define BIT_STANDBY_RUN 6
`define BIT_OUT_ENABLE 3
`define BIT_FILT_LO 4
`define BIT_CLOCK_CHOICE 6
`define BIT_EDGE 7
`define BIT_SLEEP_IDLE 0
`define BIT_SLEEP_STANDBY 1
// ----------------------------------------
// codes
// ----------------------------------------
`define SEQ_OFF 4'h0
`define SEQ_DFF 4'h1
`define SEQ_JK 4'h2
`define SEQ_LATCH 4'h3
`define SEQ_RS 4'h4
`define FILT_OFF 2'h0
`define FILT_SYNC 2'h1
`define FILT_FILTER 2'h2
`define SEL_MASK 4'h0
`define SEL_FEEDBACK 4'h1
`define SEL_CHAIN 4'h2
`define SEL_EVENT_A 4'h3
`define SEL_EVENT_B 4'h4
`define SEL_PIN 4'h5
`define SEL_PERIPH_0 4'h6
`define SEL_PERIPH_1 4'h7
`define SEL_PERIPH_2 4'h8
`define SEL_PERIPH_4 4'ha
`define SEL_PERIPH_5 4'hb
`define REG_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: verilog/glue_lut_pair.v
// glue-logic unit: two three-input tables, shared storage element, axi4-lite
`timescale 1ns/1ps
`include "glue_lut_map.vh"
module glue_lut_pair (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire event_line_a,
	input wire event_line_b,
	input wire [2:0] table0_pins,
	input wire [2:0] table1_pins,
	input wire [4:0] table0_periph,
	input wire [4:0] table1_periph,
	output reg [1:0] table_result_event,
	output reg [1:0] table_out_pin,
	output reg [1:0] table_out_pin_enable
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] unit_control;
	reg [3:0] pair_storage_select;
	reg [7:0] table_control_a [0:1];
	reg [7:0] table_control_b [0:1];
	reg [3:0] table_control_c [0:1];
	reg [7:0] table_pattern_reg [0:1];
	reg [1:0] sleep_control;
	wire unit_on = unit_control[`BIT_ENABLE];
	wire standby_run = unit_control[`BIT_STANDBY_RUN];
	wire [1:0] table_on;
	assign table_on[0] = unit_on & table_control_a[0][`BIT_ENABLE];
	assign table_on[1] = unit_on & table_control_a[1][`BIT_ENABLE];
	wire clock_stop = sleep_control[`BIT_SLEEP_STANDBY] & ~standby_run;

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	wire do_write = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = do_write;
	assign s_axi_wready = do_write;
	assign s_axi_arready = ~s_axi_rvalid;
	wire [5:0] widx = s_axi_awaddr[7:2];
	wire [5:0] ridx = s_axi_araddr[7:2];
	wire [7:0] wbyte = s_axi_wdata[7:0];
	wire wlane = s_axi_wstrb[0];
	reg waddr_ok;
	reg raddr_ok;
	reg [7:0] rbyte;
	reg storage_out;
	reg [1:0] stage_out;

	// writes to a disabled table's control registers are taken; enable-protected
	// fields only change while that table (even table for storage) is off
	always @* begin
		waddr_ok = 1'b1;
		case ({2'h0, widx})
		`IDX_UNIT_CONTROL, `IDX_PAIR_STORAGE, `IDX_T0_CONTROL_A,
		`IDX_T0_CONTROL_B, `IDX_T0_CONTROL_C, `IDX_T0_PATTERN,
		`IDX_T1_CONTROL_A, `IDX_T1_CONTROL_B, `IDX_T1_CONTROL_C,
		`IDX_T1_PATTERN, `IDX_SLEEP_CONTROL, `IDX_STATUS: waddr_ok = 1'b1;
		default: waddr_ok = 1'b0;
		endcase
	end

	always @* begin
		raddr_ok = 1'b1;
		rbyte = 8'h00;
		case ({2'h0, ridx})
		`IDX_UNIT_CONTROL: rbyte = unit_control;
		`IDX_PAIR_STORAGE: rbyte = {4'h0, pair_storage_select};
		`IDX_T0_CONTROL_A: rbyte = table_control_a[0];
		`IDX_T0_CONTROL_B: rbyte = table_control_b[0];
		`IDX_T0_CONTROL_C: rbyte = {4'h0, table_control_c[0]};
		`IDX_T0_PATTERN: rbyte = table_pattern_reg[0];
		`IDX_T1_CONTROL_A: rbyte = table_control_a[1];
		`IDX_T1_CONTROL_B: rbyte = table_control_b[1];
		`IDX_T1_CONTROL_C: rbyte = {4'h0, table_control_c[1]};
		`IDX_T1_PATTERN: rbyte = table_pattern_reg[1];
		`IDX_SLEEP_CONTROL: rbyte = {6'h00, sleep_control};
		`IDX_STATUS: rbyte = {5'h00, storage_out, stage_out};
		default: raddr_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			unit_control <= `REG_RESET;
			pair_storage_select <= 4'h0;
			table_control_a[0] <= `REG_RESET;
			table_control_a[1] <= `REG_RESET;
			table_control_b[0] <= `REG_RESET;
			table_control_b[1] <= `REG_RESET;
			table_control_c[0] <= 4'h0;
			table_control_c[1] <= 4'h0;
			table_pattern_reg[0] <= `REG_RESET;
			table_pattern_reg[1] <= `REG_RESET;
			sleep_control <= 2'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= waddr_ok ? `RESP_OKAY : `RESP_SLVERR;
				if (wlane) begin
					case ({2'h0, widx})
					`IDX_UNIT_CONTROL:
						unit_control <= wbyte & 8'h41;
					`IDX_PAIR_STORAGE:
						if (!table_control_a[0][`BIT_ENABLE])
							pair_storage_select <= wbyte[3:0];
					`IDX_T0_CONTROL_A:
						if (!table_control_a[0][`BIT_ENABLE])
							table_control_a[0] <= wbyte & 8'hf9;
						else
							table_control_a[0][`BIT_ENABLE] <= wbyte[0];
					`IDX_T0_CONTROL_B:
						if (!table_control_a[0][`BIT_ENABLE])
							table_control_b[0] <= wbyte;
					`IDX_T0_CONTROL_C:
						if (!table_control_a[0][`BIT_ENABLE])
							table_control_c[0] <= wbyte[3:0];
					`IDX_T0_PATTERN:
						if (!table_control_a[0][`BIT_ENABLE])
							table_pattern_reg[0] <= wbyte;
					`IDX_T1_CONTROL_A:
						if (!table_control_a[1][`BIT_ENABLE])
							table_control_a[1] <= wbyte & 8'hf9;
						else
							table_control_a[1][`BIT_ENABLE] <= wbyte[0];
					`IDX_T1_CONTROL_B:
						if (!table_control_a[1][`BIT_ENABLE])
							table_control_b[1] <= wbyte;
					`IDX_T1_CONTROL_C:
						if (!table_control_a[1][`BIT_ENABLE])
							table_control_c[1] <= wbyte[3:0];
					`IDX_T1_PATTERN:
						if (!table_control_a[1][`BIT_ENABLE])
							table_pattern_reg[1] <= wbyte;
					`IDX_SLEEP_CONTROL:
						sleep_control <= wbyte[1:0];
					default: ;
					endcase
				end
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rbyte};
			s_axi_rresp <= raddr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// input selection and table evaluation
	// ----------------------------------------
	// combinational results of both tables, read by the chaining source
	wire [1:0] direct_result;
	reg [2:0] in_vec [0:1];
	// events go in as arguments so that always @* sees them change
	wire [1:0] ev = {event_line_b, event_line_a};

	function sel_source;
		input [3:0] code;
		input fb;
		input chain;
		input pin;
		input [4:0] periph;
		input [1:0] evs;
		begin
			case (code)
			`SEL_MASK: sel_source = 1'b0;
			`SEL_FEEDBACK: sel_source = fb;
			`SEL_CHAIN: sel_source = chain;
			`SEL_EVENT_A: sel_source = evs[0];
			`SEL_EVENT_B: sel_source = evs[1];
			`SEL_PIN: sel_source = pin;
			`SEL_PERIPH_0: sel_source = periph[0];
			`SEL_PERIPH_1: sel_source = periph[1];
			`SEL_PERIPH_2: sel_source = periph[2];
			`SEL_PERIPH_4: sel_source = periph[3];
			`SEL_PERIPH_5: sel_source = periph[4];
			default: sel_source = 1'b0;
			endcase
		end
	endfunction

	always @* begin
		in_vec[0][0] = sel_source(table_control_b[0][3:0], storage_out,
			direct_result[1], table0_pins[0], table0_periph, ev);
		in_vec[0][1] = sel_source(table_control_b[0][7:4], storage_out,
			direct_result[1], table0_pins[1], table0_periph, ev);
		in_vec[0][2] = sel_source(table_control_c[0], storage_out,
			direct_result[1], table0_pins[2], table0_periph, ev);
		in_vec[1][0] = sel_source(table_control_b[1][3:0], storage_out,
			direct_result[0], table1_pins[0], table1_periph, ev);
		in_vec[1][1] = sel_source(table_control_b[1][7:4], storage_out,
			direct_result[0], table1_pins[1], table1_periph, ev);
		in_vec[1][2] = sel_source(table_control_c[1], storage_out,
			direct_result[0], table1_pins[2], table1_periph, ev);
	end

	// ----------------------------------------
	// per-table clocked stages
	// ----------------------------------------
	// input 2 as a clock is sampled on aclk and turned into an enable pulse;
	// it must therefore be slower than half the aclk rate
	reg [1:0] in2_prev;
	wire [1:0] tick;
	reg [1:0] sync_a;
	reg [1:0] sync_b;
	reg [1:0] filt_c;
	reg [1:0] filt_d;
	reg [1:0] edge_prev;
	reg [1:0] stage_raw;
	reg [1:0] uses_clock;
	reg [1:0] stage_raw_hold;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : table_slot
			wire [1:0] fsel = table_control_a[g][5:4];
			wire clk_choice = table_control_a[g][`BIT_CLOCK_CHOICE];
			wire edge_on = table_control_a[g][`BIT_EDGE];
			assign direct_result[g] = table_on[g] &
				table_pattern_reg[g][in_vec[g]];
			assign tick[g] = clk_choice ? (in_vec[g][2] & ~in2_prev[g])
				: ~clock_stop;
			always @* begin
				case (fsel)
				`FILT_SYNC: stage_raw[g] = sync_b[g];
				`FILT_FILTER: stage_raw[g] = (sync_b[g] & filt_c[g] &
					filt_d[g]) | (stage_raw_hold[g] & ~(~sync_b[g] &
					~filt_c[g] & ~filt_d[g]));
				default: stage_raw[g] = direct_result[g];
				endcase
				uses_clock[g] = (fsel == `FILT_SYNC) |
					(fsel == `FILT_FILTER) | edge_on |
					(pair_storage_select != `SEQ_OFF);
			end
			always @(posedge aclk) begin
				if (!aresetn)
					in2_prev[g] <= 1'b0;
				else
					in2_prev[g] <= in_vec[g][2];
			end
			always @(posedge aclk) begin
				if (!aresetn || !table_on[g]) begin
					sync_a[g] <= 1'b0;
					sync_b[g] <= 1'b0;
					filt_c[g] <= 1'b0;
					filt_d[g] <= 1'b0;
					stage_raw_hold[g] <= 1'b0;
					edge_prev[g] <= 1'b0;
				end else if (tick[g]) begin
					// two flops then a filter that changes only on three equal samples: 2..5 cycles
					sync_a[g] <= direct_result[g];
					sync_b[g] <= sync_a[g];
					filt_c[g] <= sync_b[g];
					filt_d[g] <= filt_c[g];
					stage_raw_hold[g] <= stage_raw[g];
					edge_prev[g] <= stage_raw[g];
				end
			end
			always @* begin
				if (edge_on)
					stage_out[g] = stage_raw[g] & ~edge_prev[g];
				else
					stage_out[g] = stage_raw[g];
			end
		end
	endgenerate

	// ----------------------------------------
	// pair storage element
	// ----------------------------------------
	// latch modes are built as clocked elements so the design has no real latch
	wire store_tick = tick[0];
	wire d_in = stage_out[0];
	wire g_in = stage_out[1];
	always @(posedge aclk) begin
		if (!aresetn || !table_on[0]) begin
			storage_out <= 1'b0;
		end else if (store_tick) begin
			case (pair_storage_select)
			`SEQ_DFF: if (g_in) storage_out <= d_in;
			`SEQ_JK:
				case ({d_in, g_in})
				2'b01: storage_out <= 1'b0;
				2'b10: storage_out <= 1'b1;
				2'b11: storage_out <= ~storage_out;
				default: ;
				endcase
			`SEQ_LATCH: if (g_in) storage_out <= d_in;
			`SEQ_RS:
				case ({d_in, g_in})
				2'b01: storage_out <= 1'b0;
				2'b10: storage_out <= 1'b1;
				default: ;
				endcase
			default: storage_out <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	reg [1:0] next_result;
	always @* begin
		next_result[0] = (pair_storage_select != `SEQ_OFF) ?
			storage_out : stage_out[0];
		next_result[1] = stage_out[1];
		if (clock_stop) begin
			next_result[0] = uses_clock[0] ? 1'b0 : next_result[0];
			next_result[1] = uses_clock[1] ? 1'b0 : next_result[1];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			table_result_event <= 2'b00;
			table_out_pin <= 2'b00;
			table_out_pin_enable <= 2'b11;
		end else begin
			table_result_event <= next_result & table_on;
			table_out_pin <= next_result & table_on;
			table_out_pin_enable[0] <= ~table_control_a[0][`BIT_OUT_ENABLE];
			table_out_pin_enable[1] <= ~table_control_a[1][`BIT_OUT_ENABLE];
		end
	end
endmodule // glue_lut_pair

// file: sim/far_side_model.sv
// registered sources standing for event lines, pins and peripherals
`timescale 1ns/1ps
module far_side_model (
	input wire aclk,
	input wire [17:0] want,
	output reg event_line_a,
	output reg event_line_b,
	output reg [2:0] table0_pins,
	output reg [2:0] table1_pins,
	output reg [4:0] table0_periph,
	output reg [4:0] table1_periph
);
	// ----------------------------------------
	// sources change only on the clock, as an on-chip driver would
	// ----------------------------------------
	always @(posedge aclk) begin
		event_line_a <= want[0];
		event_line_b <= want[1];
		table0_pins <= want[4:2];
		table1_pins <= want[7:5];
		table0_periph <= want[12:8];
		table1_periph <= want[17:13];
	end
endmodule // far_side_model

// file: sim/glue_lut_pair_asserts.sv
// bus and reset checks on the ports of the glue-logic unit
`timescale 1ns/1ps
`include "glue_lut_map.vh"
module glue_lut_pair_asserts (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_wvalid,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] table_result_event,
	input wire [1:0] table_out_pin_enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endsequence
	sequence rd_take;
		s_axi_arvalid && !s_axi_rvalid;
	endsequence
	chk_write_answer: assert property (wr_take |=> s_axi_bvalid)
		else $error("write not answered next cycle");
	chk_write_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_write_ends: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid)
		else $error("write response lingers");
	chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_read_upper: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	chk_unmapped_read: assert property (rd_take ##0
		s_axi_araddr == 8'hfc |=> s_axi_rresp == `RESP_SLVERR)
		else $error("unmapped read not refused");
	chk_reset_idle: assert property ($rose(aresetn)
		|-> table_result_event == 2'h0 && table_out_pin_enable == 2'h3)
		else $error("outputs not idle after reset");
endmodule // glue_lut_pair_asserts
bind glue_lut_pair glue_lut_pair_asserts i_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .table_result_event,
	.table_out_pin_enable);

// file: sim/glue_lut_pair_test.sv
// self-checking bench of the glue-logic unit
`timescale 1ns/1ps
`include "glue_lut_map.vh"
module glue_lut_pair_test;
	reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg s_axi_arvalid, s_axi_rready;
	reg [7:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata, rd;
	reg [17:0] want;
	reg [1:0] rsp;
	// when set, bready and rready come late so the slave must hold its answer
	reg slow;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, ev_a, ev_b;
	wire [1:0] s_axi_bresp, s_axi_rresp, res, pin, pin_en;
	wire [31:0] s_axi_rdata;
	wire [2:0] p0, p1;
	wire [4:0] q0, q1;
	integer fails, cmp_count, d0, d1, n, i;
	glue_lut_pair i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .event_line_a(ev_a),
		.event_line_b(ev_b), .table0_pins(p0), .table1_pins(p1),
		.table0_periph(q0), .table1_periph(q1),
		.table_result_event(res), .table_out_pin(pin),
		.table_out_pin_enable(pin_en));
	far_side_model i_far (.aclk(aclk), .want(want), .event_line_a(ev_a),
		.event_line_b(ev_b), .table0_pins(p0), .table1_pins(p1),
		.table0_periph(q0), .table1_periph(q1));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task check(input [31:0] seen, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, fails);
			if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	task cyc(input integer c);
		repeat (c) @(posedge aclk);
	endtask
	task put(input [17:0] v);
		begin
			@(posedge aclk);
			want <= v;
		end
	endtask
	// both write channels offered together, each released once taken
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h000000, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= !slow;
			do @(posedge aclk);
			while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
			s_axi_awvalid <= 1'b0;
			s_axi_wvalid <= 1'b0;
			if (slow) begin
				repeat (3) @(posedge aclk);
				s_axi_bready <= 1'b1;
			end
			do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rdr(input [7:0] a);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= !slow;
			do @(posedge aclk); while (s_axi_arready !== 1'b1);
			s_axi_arvalid <= 1'b0;
			if (slow) begin
				repeat (3) @(posedge aclk);
				s_axi_rready <= 1'b1;
			end
			do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
	// flips table 0 input pin 0 and counts cycles until its result moves
	task lat(output integer d);
		reg old;
		begin
			old = res[0];
			put(want ^ 18'h00004);
			d = 0;
			while (res[0] === old && d < 20) begin
				@(posedge aclk);
				d = d + 1;
			end
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task test_regs;
		begin
			rdr(8'h00); check(rd, 32'h0);
			rdr(8'h14); check(rd, 32'h0);
			rdr(8'h04); check(rd, 32'h0);
			slow = 1'b1;
			wr(8'h20, 8'h5a); rdr(8'h20); check(rd, 32'h5a);
			slow = 1'b0;
			rdr(8'hfc); check(rsp, `RESP_SLVERR);
			$display("test_regs done");
		end
	endtask
	task test_truth;
		begin
			wr(8'h00, 8'h01); wr(8'h18, 8'h55); wr(8'h1c, 8'h05);
			wr(8'h20, 8'hb4); wr(8'h14, 8'h09);
			for (i = 0; i < 8; i = i + 1) begin
				put({13'h0, i[2:0], 2'h0});
				cyc(3);
				check(res[0], (8'hb4 >> i) & 8'h01);
			end
			check(pin_en[0], 1'b0);
			check(pin[0], 1'b1);
			wr(8'h00, 8'h00); cyc(3); check(res[0], 1'b0);
			wr(8'h14, 8'h00);
			$display("test_truth done");
		end
	endtask
	task test_event;
		begin
			wr(8'h00, 8'h01); wr(8'h28, 8'h43); wr(8'h2c, 8'h00);
			wr(8'h30, 8'h08); wr(8'h24, 8'h01);
			for (i = 0; i < 4; i = i + 1) begin
				put({16'h0, i[1:0]});
				cyc(3);
				check(res[1], i == 3);
			end
			wr(8'h24, 8'h00); cyc(3); check(res[1], 1'b0);
			$display("test_event done");
		end
	endtask
	task test_chain;
		begin
			wr(8'h28, 8'h05); wr(8'h30, 8'haa); wr(8'h24, 8'h01);
			wr(8'h18, 8'h02); wr(8'h1c, 8'h00); wr(8'h20, 8'haa);
			wr(8'h14, 8'h01);
			for (i = 0; i < 2; i = i + 1) begin
				put({12'h0, i[0], 5'h0});
				cyc(4);
				check(res[0], i);
			end
			wr(8'h14, 8'h00); wr(8'h24, 8'h00);
			$display("test_chain done");
		end
	endtask
	task test_filter;
		begin
			wr(8'h18, 8'h05); put(18'h0); wr(8'h14, 8'h01); cyc(4);
			lat(d0);
			wr(8'h14, 8'h00); wr(8'h14, 8'h21); cyc(10);
			lat(d1);
			check(d1 - d0 >= 2 && d1 - d0 <= 5, 1);
			// edge pulse needs a synchronizer chosen alongside it
			wr(8'h14, 8'h00); put(18'h0); wr(8'h14, 8'h91); cyc(8);
			put(18'h00004);
			n = 0;
			for (i = 0; i < 14; i = i + 1) begin
				@(posedge aclk);
				if (res[0] === 1'b1) n = n + 1;
			end
			check(n, 1);
			wr(8'h14, 8'h00);
			$display("test_filter done");
		end
	endtask
	// rows of even input, odd input, clock pulse, expected storage output,
	// row 0 lowest
	localparam [27:0] JK_ROWS = 28'hb65fe3b;
	task seq_rows(input [27:0] rows, input integer cnt);
		reg [3:0] r;
		begin
			for (i = 0; i < cnt; i = i + 1) begin
				r = rows[i*4 +: 4];
				put({12'h0, r[2], 2'h0, r[3], 2'h0});
				cyc(4);
				put({12'h0, r[2], r[1], 1'b0, r[3], 2'h0});
				cyc(4);
				put({12'h0, r[2], 2'h0, r[3], 2'h0});
				cyc(4);
				rdr(8'h44);
				check(rd[2], r[0]);
			end
		end
	endtask
	task test_jk;
		begin
			put(18'h0); wr(8'h04, 8'h02); rdr(8'h04);
			check(rd, `SEQ_JK);
			wr(8'h1c, 8'h05); wr(8'h14, 8'h41);
			wr(8'h28, 8'h05); wr(8'h24, 8'h01);
			seq_rows(JK_ROWS, 7);
			wr(8'h14, 8'h00); cyc(3);
			rdr(8'h44); check(rd[2], 1'b0);
			$display("test_jk done");
		end
	endtask
	// other storage modes, feedback, odd-table chaining and standby
	task test_seq;
		begin
			wr(8'h04, 8'h01);
			wr(8'h14, 8'h41);
			seq_rows(28'h63fa, 4);
			wr(8'h14, 8'h00);
			wr(8'h04, 8'h03);
			wr(8'h14, 8'h41);
			seq_rows(28'h63fa, 4);
			wr(8'h14, 8'h00);
			wr(8'h04, 8'h04);
			wr(8'h14, 8'h41);
			seq_rows(28'h863b, 4);
			wr(8'h24, 8'h00);
			wr(8'h28, 8'h15);
			wr(8'h30, 8'hcc);
			wr(8'h24, 8'h01);
			cyc(3);
			check(res[1], 1'b0);
			seq_rows(28'h000000b, 1);
			cyc(3);
			check(res[1], 1'b1);
			wr(8'h40, 8'h02);
			cyc(3);
			check(res, 2'b00);
			wr(8'h00, 8'h41);
			cyc(3);
			check(res, 2'b11);
			wr(8'h00, 8'h01);
			wr(8'h40, 8'h00);
			wr(8'h24, 8'h00);
			wr(8'h28, 8'h02);
			wr(8'h30, 8'haa);
			wr(8'h24, 8'h01);
			put(18'h00004);
			cyc(3);
			check(res[1], 1'b1);
			put(18'h00000);
			cyc(3);
			check(res[1], 1'b0);
			$display("test_seq done");
		end
	endtask
	// ----------------------------------------
	// clock, reset, sequence and watchdog
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		fails = 0;
		cmp_count = 0;
		aresetn = 1'b0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		want = 18'h0;
		slow = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		test_regs;
		test_truth;
		test_event;
		test_chain;
		test_filter;
		test_jk;
		test_seq;
		end_sim;
	end
	initial begin
		repeat (50000) @(posedge aclk);
		fails = fails + 1;
		end_sim;
	end
endmodule // glue_lut_pair_test
